/* File: design/program_counter_sequencer.sv */
// Program counter sequencer: next fetch address for a 4-bit core.
// Assumes the decoder presents one flow op per instruction cycle with
// instr_valid, and that program memory returns data in the same cycle as addr.
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_cfg.svh"

module program_counter_sequencer
  import pc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Other reset sources, already synchronous to clk
  input  wire logic                      wdt_reset,
  input  wire logic                      ce_reset,
  // Decoder
  input  wire logic                      instr_valid,
  input  wire pc_seq_pkg::flow_op_t      flow_op,
  input  wire logic [`PC_CTR_W-1:0]      direct_target,
  input  wire logic [`PC_SYS_BLK_W-1:0]  syscall_block_field,
  input  wire logic [`PC_SYS_WRD_W-1:0]  syscall_word_field,
  // Address pointer register
  input  wire logic [`PC_ADDR_W-1:0]     address_pointer_register,
  // Interrupt acceptance
  input  wire logic                      irq_accept,
  input  wire pc_seq_pkg::irq_src_t      irq_source,
  // Program memory
  input  wire logic [`PC_WORD_W-1:0]     mem_rdata,
  output logic [`PC_ADDR_W-1:0]          fetch_addr,
  // Observed state
  output logic [`PC_CTR_W-1:0]           pc_count,
  output logic                           segment_select_bit,
  output logic [`PC_WORD_W-1:0]          fetch_buffer,
  output logic                           fetch_buffer_valid,
  output logic                           table_busy,
  output logic [`PC_STK_IDX_W-1:0]       return_stack_index
);

  import pc_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    seq_state_t                st;
    logic                      busy;
    logic [`PC_CTR_W-1:0]      ctr;
    logic                      seg;
    logic [`PC_ADDR_W-1:0]     fetch;
    logic [`PC_ADDR_W-1:0]     resume;
    logic [`PC_WORD_W-1:0]     buf_word;
    logic                      buf_valid;
    logic [`PC_STK_IDX_W-1:0]  idx_mirror;
  } seq_t;

  seq_t state_reg;
  seq_t state_next;

  logic                     any_reset;
  logic                     stk_push;
  logic                     stk_pop;
  logic [`PC_ADDR_W-1:0]    stk_push_addr;
  logic [`PC_ADDR_W-1:0]    stk_top;
  logic [`PC_STK_IDX_W-1:0] stk_idx;
  logic [`PC_CTR_W-1:0]     irq_vector;

  function automatic logic [`PC_CTR_W-1:0] ctr_of(input logic [`PC_ADDR_W-1:0] a);
    ctr_of = a[`PC_CTR_W-1:0];
  endfunction : ctr_of

  function automatic logic seg_of(input logic [`PC_ADDR_W-1:0] a);
    seg_of = a[`PC_CTR_W];
  endfunction : seg_of

  // Three reset sources merge into one synchronous clear
  assign any_reset = !rst_n || wdt_reset || ce_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  irq_vector_map u_vec (
    .src    (irq_source),
    .vector (irq_vector)
  );

  return_stack u_stk (
    .clk       (clk),
    .rst_n     (!any_reset),
    .push      (stk_push),
    .pop       (stk_pop),
    .push_addr (stk_push_addr),
    .top_addr  (stk_top),
    .index     (stk_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-address selection

  always_comb begin
    state_next    = state_reg;
    stk_push      = 1'b0;
    stk_pop       = 1'b0;
    // Return address is the word after the executing instruction
    stk_push_addr = {state_reg.seg, state_reg.ctr + `PC_ONE};
    state_next.buf_valid  = 1'b0;
    state_next.idx_mirror = stk_idx;

    unique case (state_reg.st)
      ST_RUN: begin
        if (irq_accept) begin
          // Interrupt beats the pending instruction; it re-executes on return
          stk_push      = 1'b1;
          stk_push_addr = {state_reg.seg, state_reg.ctr};
          state_next.seg = `PC_SEG_ZERO;
          state_next.ctr = irq_vector;
        end else if (instr_valid) begin
          unique case (flow_op)
            OP_DIRECT_JUMP: begin
              // Page bits come from the operand, segment stays
              state_next.ctr = direct_target;
            end
            OP_INDIRECT_JMP: begin
              state_next.seg = seg_of(address_pointer_register);
              state_next.ctr = ctr_of(address_pointer_register);
            end
            OP_DIRECT_CALL: begin
              stk_push = 1'b1;
              state_next.ctr = {2'b00, direct_target[`PC_DCALL_W-1:0]};
            end
            OP_INDIRECT_CAL: begin
              stk_push = 1'b1;
              state_next.seg = seg_of(address_pointer_register);
              state_next.ctr = ctr_of(address_pointer_register);
            end
            OP_SYSTEM_CALL: begin
              stk_push = 1'b1;
              state_next.seg = `PC_SEG_SYSTEM;
              state_next.ctr = {2'b00, syscall_block_field, 4'h0,
                                syscall_word_field};
            end
            OP_PLAIN_RET, OP_RET_SKIP, OP_INT_RET: begin
              stk_pop = 1'b1;
              state_next.seg = seg_of(stk_top);
              state_next.ctr = ctr_of(stk_top);
            end
            OP_TABLE_READ: begin
              // Park the resume point; fetch the constant next cycle
              state_next.st     = ST_TABLE;
              state_next.resume = {state_reg.seg, state_reg.ctr + `PC_ONE};
            end
            default: begin
              // Counter wraps at 13 bits; no carry into segment
              state_next.ctr = state_reg.ctr + `PC_ONE;
            end
          endcase
        end
      end
      ST_TABLE: begin
        // Word for the pointer address arrives now
        state_next.buf_word  = mem_rdata;
        state_next.buf_valid = 1'b1;
        state_next.st        = ST_RUN;
        state_next.seg       = seg_of(state_reg.resume);
        state_next.ctr       = ctr_of(state_reg.resume);
      end
      default: state_next.st = ST_RUN;
    endcase

    // Busy kept in its own flop so the output carries no decode
    state_next.busy = (state_next.st == ST_TABLE);
    // Fetch address registered so the memory port is glitch free
    if (state_next.st == ST_TABLE) begin
      state_next.fetch = address_pointer_register;
    end else begin
      state_next.fetch = {state_next.seg, state_next.ctr};
    end
  end

  always_ff @(posedge clk) begin
    if (any_reset) begin
      state_reg <= '0;
      state_reg.idx_mirror <= `PC_STK_RST_IDX;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from state flops

  assign fetch_addr         = state_reg.fetch;
  assign pc_count           = state_reg.ctr;
  assign segment_select_bit = state_reg.seg;
  assign fetch_buffer       = state_reg.buf_word;
  assign fetch_buffer_valid = state_reg.buf_valid;
  assign table_busy         = state_reg.busy;
  assign return_stack_index = state_reg.idx_mirror;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_reset_zero: assert property (@(posedge clk) !rst_n |=>
      fetch_addr == '0 && segment_select_bit == 1'b0)
    else $error("reset did not clear fetch address");

  a_step_wrap: assert property (@(posedge clk) disable iff (any_reset)
      (state_reg.st == ST_RUN && !irq_accept && instr_valid && flow_op == OP_STEP)
      |=> pc_count == $past(pc_count) + `PC_ONE
          && segment_select_bit == $past(segment_select_bit))
    else $error("step changed segment or missed increment");

  a_jump_seg_kept: assert property (@(posedge clk) disable iff (any_reset)
      (state_reg.st == ST_RUN && !irq_accept && instr_valid && flow_op == OP_DIRECT_JUMP)
      |=> segment_select_bit == $past(segment_select_bit)
          && pc_count == $past(direct_target))
    else $error("direct jump crossed segment");

  a_call_page0: assert property (@(posedge clk) disable iff (any_reset)
      (state_reg.st == ST_RUN && !irq_accept && instr_valid && flow_op == OP_DIRECT_CALL)
      |=> pc_count[`PC_PAGE_HI:`PC_PAGE_LO] == 2'b00
          && segment_select_bit == $past(segment_select_bit))
    else $error("direct call left page 0");

  a_syscall_seg: assert property (@(posedge clk) disable iff (any_reset)
      (state_reg.st == ST_RUN && !irq_accept && instr_valid && flow_op == OP_SYSTEM_CALL)
      |=> segment_select_bit && pc_count[7:4] == 4'h0
          && pc_count[3:0] == $past(syscall_word_field))
    else $error("system call address wrong");

  a_irq_vector: assert property (@(posedge clk) disable iff (any_reset)
      (state_reg.st == ST_RUN && irq_accept && irq_source == SRC_CE)
      |=> !segment_select_bit && pc_count == {9'h000, `PC_VEC_CE})
    else $error("interrupt vector wrong");

  a_ind_jump: assert property (@(posedge clk) disable iff (any_reset)
      (state_reg.st == ST_RUN && !irq_accept && instr_valid && flow_op == OP_INDIRECT_JMP)
      |=> fetch_addr == $past(address_pointer_register))
    else $error("indirect jump address wrong");

  a_table_read: assert property (@(posedge clk) disable iff (any_reset)
      (state_reg.st == ST_RUN && !irq_accept && instr_valid && flow_op == OP_TABLE_READ)
      |=> table_busy ##1 fetch_buffer_valid && !table_busy)
    else $error("table read sequence broken");

  a_stack_push: assert property (@(posedge clk) disable iff (any_reset)
      stk_push |=> stk_idx == $past(stk_idx) - 4'h1)
    else $error("push did not decrement index");

  a_ind_call: assert property (@(posedge clk) disable iff (any_reset)
      (state_reg.st == ST_RUN && !irq_accept && instr_valid && flow_op == OP_INDIRECT_CAL)
      |=> fetch_addr == $past(address_pointer_register)
          && stk_idx == $past(stk_idx) - 4'h1)
    else $error("indirect call address wrong");

  a_return_load: assert property (@(posedge clk) disable iff (any_reset)
      (state_reg.st == ST_RUN && !irq_accept && instr_valid
       && flow_op inside {OP_PLAIN_RET, OP_RET_SKIP, OP_INT_RET})
      |=> fetch_addr == $past(stk_top) && stk_idx == $past(stk_idx) + 4'h1)
    else $error("return did not load the stack slot");

  a_irq_push: assert property (@(posedge clk) disable iff (any_reset)
      (state_reg.st == ST_RUN && irq_accept)
      |=> stk_idx == $past(stk_idx) - 4'h1 && !segment_select_bit)
    else $error("interrupt did not push a return address");

  // Anything offered while busy is dropped; flow resumes after the read
  a_busy_refuse: assert property (@(posedge clk) disable iff (any_reset)
      table_busy |=> !table_busy && stk_idx == $past(stk_idx)
          && fetch_addr == {$past(segment_select_bit), $past(pc_count) + `PC_ONE})
    else $error("table read did not resume after its fetch");

  c_syscall: cover property (@(posedge clk) disable iff (any_reset)
      instr_valid && flow_op == OP_SYSTEM_CALL ##1 instr_valid && flow_op == OP_PLAIN_RET);
  c_irq: cover property (@(posedge clk) disable iff (any_reset) irq_accept);
  c_table: cover property (@(posedge clk) disable iff (any_reset) fetch_buffer_valid);
  c_wrap: cover property (@(posedge clk) disable iff (any_reset)
      pc_count == 13'h1FFF ##1 pc_count == 13'h0000);

endmodule : program_counter_sequencer

`default_nettype wire

/* File: inc/pc_seq_cfg.svh */
// Constants for the program counter sequencer: widths, field positions,
// interrupt vectors and reset values.
// Included by the package and by every design file; definitions only.
`ifndef PC_SEQ_CFG_SVH
`define PC_SEQ_CFG_SVH

`define PC_CTR_W        13
`define PC_ADDR_W       14
`define PC_WORD_W       16
`define PC_STK_IDX_W    4
`define PC_STK_DEPTH    15
`define PC_STK_RST_IDX  4'hF
`define PC_MEM_WORDS    16384
`define PC_CTR_ZERO     13'h0000
`define PC_SEG_ZERO     1'h0
`define PC_SEG_SYSTEM   1'h1
`define PC_ONE          13'h0001
`define PC_PAGE_HI      12
`define PC_PAGE_LO      11
`define PC_DCALL_W      11
`define PC_SYS_BLK_W    3
`define PC_SYS_WRD_W    4
`define PC_VEC_W        4
`define PC_VEC_CE       4'hC
`define PC_VEC_EXT0     4'hB
`define PC_VEC_EXT1     4'hA
`define PC_VEC_EXT2     4'h9
`define PC_VEC_EXT3     4'h8
`define PC_VEC_EXT4     4'h7
`define PC_VEC_TMR0     4'h6
`define PC_VEC_TMR1     4'h5
`define PC_VEC_TMR2     4'h4
`define PC_VEC_TMR3     4'h3
`define PC_VEC_SER0     4'h2
`define PC_VEC_SER1     4'h1
`define PC_SRC_W        4
`define PC_OP_W         4

`endif

/* File: inc/pc_seq_pkg.sv */
// Types shared by the program counter sequencer files.
// Assumes pc_seq_cfg.svh is on the include path.
`include "pc_seq_cfg.svh"

package pc_seq_pkg;

  // Flow operation requested by the decoder for the current instruction
  typedef enum logic [`PC_OP_W-1:0] {
    OP_STEP         = 4'h0,
    OP_DIRECT_JUMP  = 4'h1,
    OP_INDIRECT_JMP = 4'h2,
    OP_DIRECT_CALL  = 4'h3,
    OP_INDIRECT_CAL = 4'h4,
    OP_TABLE_READ   = 4'h5,
    OP_SYSTEM_CALL  = 4'h6,
    OP_PLAIN_RET    = 4'h7,
    OP_RET_SKIP     = 4'h8,
    OP_INT_RET      = 4'h9
  } flow_op_t;

  // Interrupt source granted by the acceptance logic
  typedef enum logic [`PC_SRC_W-1:0] {
    SRC_CE   = 4'h0,
    SRC_EXT0 = 4'h1,
    SRC_EXT1 = 4'h2,
    SRC_EXT2 = 4'h3,
    SRC_EXT3 = 4'h4,
    SRC_EXT4 = 4'h5,
    SRC_TMR0 = 4'h6,
    SRC_TMR1 = 4'h7,
    SRC_TMR2 = 4'h8,
    SRC_TMR3 = 4'h9,
    SRC_SER0 = 4'hA,
    SRC_SER1 = 4'hB
  } irq_src_t;

  // Table read runs in two phases: fetch constant, then resume
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_TABLE = 2'b01
  } seq_state_t;

endpackage : pc_seq_pkg

/* File: design/irq_vector_map.sv */
// Maps an accepted interrupt source to its vector within page 0.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_cfg.svh"

module irq_vector_map
  import pc_seq_pkg::*;
(
  // Source in, vector out
  input  wire pc_seq_pkg::irq_src_t src,
  output logic [`PC_CTR_W-1:0]      vector
);

  logic [`PC_VEC_W-1:0] low;

  always_comb begin
    low = `PC_VEC_CE;
    unique case (src)
      SRC_CE:   low = `PC_VEC_CE;
      SRC_EXT0: low = `PC_VEC_EXT0;
      SRC_EXT1: low = `PC_VEC_EXT1;
      SRC_EXT2: low = `PC_VEC_EXT2;
      SRC_EXT3: low = `PC_VEC_EXT3;
      SRC_EXT4: low = `PC_VEC_EXT4;
      SRC_TMR0: low = `PC_VEC_TMR0;
      SRC_TMR1: low = `PC_VEC_TMR1;
      SRC_TMR2: low = `PC_VEC_TMR2;
      SRC_TMR3: low = `PC_VEC_TMR3;
      SRC_SER0: low = `PC_VEC_SER0;
      SRC_SER1: low = `PC_VEC_SER1;
      // Unused codes fall back to the highest-priority vector
      default:  low = `PC_VEC_CE;
    endcase
    vector = {{(`PC_CTR_W-`PC_VEC_W){1'b0}}, low};
  end

endmodule : irq_vector_map

`default_nettype wire

/* File: design/return_stack.sv */
// Return-address stack: fifteen slots addressed by a 4-bit index.
// Index resets to all ones; the sequencer drives push/pop strobes.
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_cfg.svh"

module return_stack #(
  parameter int DEPTH = `PC_STK_DEPTH
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Push writes after decrement; pop reads current slot then increments
  input  wire logic                      push,
  input  wire logic                      pop,
  input  wire logic [`PC_ADDR_W-1:0]     push_addr,
  output logic [`PC_ADDR_W-1:0]          top_addr,
  output logic [`PC_STK_IDX_W-1:0]       index
);

  logic [`PC_ADDR_W-1:0]    slot_reg [DEPTH];
  logic [`PC_STK_IDX_W-1:0] idx_reg;
  logic [`PC_STK_IDX_W-1:0] idx_dec;

  assign idx_dec = idx_reg - 4'h1;
  assign index   = idx_reg;
  // Index 15 has no slot and reads as zero
  assign top_addr = (int'(idx_reg) < DEPTH) ? slot_reg[idx_reg] : '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_reg <= `PC_STK_RST_IDX;
    end else if (push) begin
      idx_reg <= idx_dec;
    end else if (pop) begin
      idx_reg <= idx_reg + 4'h1;
    end
  end

  // Slots carry no reset: contents are undefined until pushed
  always_ff @(posedge clk) begin
    if (rst_n && push && int'(idx_dec) < DEPTH) begin
      slot_reg[idx_dec] <= push_addr;
    end
  end

endmodule : return_stack

`default_nettype wire

/* File: verification/prog_mem_model.sv */
// Program memory model: read-only pattern computed from the address, one 16-bit word per address.
// Assumes the fetch address stays stable for the cycle in which it is sampled.
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_cfg.svh"

module prog_mem_model (
  // Fetch port
  input  wire logic [`PC_ADDR_W-1:0] addr,
  output logic [`PC_WORD_W-1:0]      rdata
);
  // An address pattern, so that a word fetched from the wrong place never matches
  always_comb begin
    rdata = {2'b01, addr} ^ 16'hA5C3;
  end
endmodule : prog_mem_model
`default_nettype wire

/* File: verification/test_program_counter_sequencer.sv */
// Self-checking bench for the program counter sequencer.
// Assumes pc_seq_pkg is compiled first and pc_seq_cfg.svh is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_cfg.svh"

module test_program_counter_sequencer;
  import pc_seq_pkg::*;

  typedef struct {
    logic [`PC_ADDR_W-1:0]    addr;
    logic                     busy;
    logic                     bvalid;
    logic [`PC_WORD_W-1:0]    word;
    logic [`PC_STK_IDX_W-1:0] idx;
    logic                     rst;
  } note_t;

  logic                        clk = 1'b0;
  logic                        rst_n, wdt_reset, ce_reset, instr_valid, irq_accept;
  flow_op_t                    flow_op;
  irq_src_t                    irq_source;
  logic [`PC_CTR_W-1:0]        direct_target, pc_count, m_pc;
  logic [2:0]                  syscall_block_field;
  logic [3:0]                  syscall_word_field, m_idx, idx_hold;
  logic [`PC_ADDR_W-1:0]       address_pointer_register, fetch_addr, m_ar;
  logic [`PC_ADDR_W-1:0]       stk [16];
  logic [`PC_WORD_W-1:0]       mem_rdata, fetch_buffer;
  logic                        segment_select_bit, fetch_buffer_valid, table_busy;
  logic                        m_seg, m_busy;
  logic [3:0]                  return_stack_index;
  note_t                       notes [$];
  integer                      seed = 32'hCC8F3284;
  int                          miscompares = 0;
  int                          check_count = 0;

  always #50 clk = ~clk;

  program_counter_sequencer dut (
    .clk(clk), .rst_n(rst_n), .wdt_reset(wdt_reset), .ce_reset(ce_reset),
    .instr_valid(instr_valid), .flow_op(flow_op), .direct_target(direct_target),
    .syscall_block_field(syscall_block_field), .syscall_word_field(syscall_word_field),
    .address_pointer_register(address_pointer_register), .irq_accept(irq_accept),
    .irq_source(irq_source), .mem_rdata(mem_rdata), .fetch_addr(fetch_addr),
    .pc_count(pc_count), .segment_select_bit(segment_select_bit),
    .fetch_buffer(fetch_buffer), .fetch_buffer_valid(fetch_buffer_valid),
    .table_busy(table_busy), .return_stack_index(return_stack_index)
  );

  prog_mem_model mem (
    .addr(fetch_addr),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] word_at(input logic [13:0] a);
    return {2'b01, a} ^ 16'hA5C3;
  endfunction : word_at

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
    end
  endtask : check

  task automatic push_ret(input logic [13:0] a);
    m_idx = m_idx - 4'h1;
    stk[m_idx] = a;
  endtask : push_ret

  // Reference model: works out what the inputs just driven must produce
  task automatic apply();
    note_t n;
    n.bvalid = 1'b0;
    n.word = 16'h0000;
    n.rst = !rst_n || wdt_reset || ce_reset;
    if (n.rst) begin
      m_seg = 1'b0;
      m_pc = 13'h0000;
      m_idx = 4'hF;
      m_busy = 1'b0;
    end else if (m_busy) begin
      m_busy = 1'b0;
      n.bvalid = 1'b1;
      n.word = word_at(m_ar);
    end else if (irq_accept) begin
      push_ret({m_seg, m_pc});
      m_seg = 1'b0;
      m_pc = 13'(12 - int'(irq_source));
    end else if (instr_valid) begin
      case (flow_op)
        OP_DIRECT_JUMP:  m_pc = direct_target;
        OP_INDIRECT_JMP: {m_seg, m_pc} = address_pointer_register;
        OP_DIRECT_CALL: begin
          push_ret({m_seg, 13'(m_pc + 13'h1)});
          m_pc = {2'b00, direct_target[10:0]};
        end
        OP_INDIRECT_CAL: begin
          push_ret({m_seg, 13'(m_pc + 13'h1)});
          {m_seg, m_pc} = address_pointer_register;
        end
        OP_TABLE_READ: begin
          m_ar = address_pointer_register;
          m_busy = 1'b1;
          m_pc = m_pc + 13'h1;
        end
        OP_SYSTEM_CALL: begin
          push_ret({m_seg, 13'(m_pc + 13'h1)});
          m_seg = 1'b1;
          m_pc = {2'b00, syscall_block_field, 4'h0, syscall_word_field};
        end
        OP_PLAIN_RET, OP_RET_SKIP, OP_INT_RET: begin
          {m_seg, m_pc} = stk[m_idx];
          m_idx = m_idx + 4'h1;
        end
        default: m_pc = m_pc + 13'h1;
      endcase
    end
    n.addr = m_busy ? m_ar : {m_seg, m_pc};
    n.busy = m_busy;
    n.idx = m_idx;
    notes.push_back(n);
  endtask : apply

  task automatic op_at(input logic [3:0] op, input logic [12:0] dt,
                       input logic [13:0] ar, input logic irq);
    @(negedge clk);
    rst_n = 1'b1;
    instr_valid = 1'b1;
    flow_op = flow_op_t'(op);
    direct_target = dt;
    syscall_block_field = dt[6:4];
    syscall_word_field = dt[3:0];
    address_pointer_register = ar;
    irq_accept = irq;
    irq_source = SRC_CE;
    apply();
  endtask : op_at

  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: each result launched at a rising edge is judged at the next fall
  initial begin : watch
    note_t n;
    idx_hold = 4'hF;
    forever begin
      @(posedge clk);
      if (notes.size() > 0) begin
        n = notes.pop_front();
        @(negedge clk);
        check(16'(fetch_addr), 16'(n.addr));
        check(16'(table_busy), 16'(n.busy));
        check(16'(fetch_buffer_valid), 16'(n.bvalid));
        if (n.bvalid) check(fetch_buffer, n.word);
        if (!n.busy) check(16'(segment_select_bit), 16'(n.addr[13]));
        if (!n.busy) check(16'(pc_count), 16'(n.addr[12:0]));
        if (n.rst) idx_hold = 4'hF;
        check(16'(return_stack_index), 16'(idx_hold));
        idx_hold = n.idx;
      end
    end
  end

  initial begin : stim
    logic [31:0] r, r2;
    {wdt_reset, ce_reset, instr_valid, irq_accept} = 4'h0;
    {rst_n, direct_target} = '0;
    flow_op = OP_STEP;
    irq_source = SRC_CE;
    {syscall_block_field, syscall_word_field, address_pointer_register} = '0;
    repeat (4) begin
      @(negedge clk);
      rst_n = 1'b0;
      apply();
    end
    // Wrap in both segments, system call reach, refused op in busy cycle
    op_at(4'h1, 13'h1FFF, 14'h0000, 1'b0);
    op_at(4'h0, 13'h0000, 14'h0000, 1'b0);
    op_at(4'h6, 13'h007F, 14'h0000, 1'b0);
    op_at(4'h1, 13'h1FFF, 14'h0000, 1'b0);
    op_at(4'h0, 13'h0000, 14'h0000, 1'b0);
    op_at(4'h5, 13'h0000, 14'h3FFF, 1'b0);
    op_at(4'h1, 13'h0ABC, 14'h0000, 1'b1);
    op_at(4'h3, 13'h1FFF, 14'h0000, 1'b1);
    op_at(4'h9, 13'h0000, 14'h0000, 1'b0);
    op_at(4'h7, 13'h0000, 14'h0000, 1'b0);
    $display("directed flow test done");
    for (int i = 0; i < 800; i++) begin
      @(negedge clk);
      r = $random(seed);
      r2 = $random(seed);
      rst_n = (r[31:26] != 6'h00);
      wdt_reset = (r[25:20] == 6'h00);
      ce_reset = (r[19:14] == 6'h00);
      instr_valid = r[8] | r[9];
      irq_accept = (r[7:4] == 4'h0);
      flow_op = flow_op_t'(r[3:0]);
      irq_source = irq_src_t'(4'(r2[7:0] % 12));
      direct_target = r2[20:8];
      syscall_block_field = r2[23:21];
      syscall_word_field = r2[27:24];
      address_pointer_register = r[27:14];
      // Keep the stack inside its fifteen slots
      if (m_idx == 4'h0) begin
        irq_accept = 1'b0;
        if (r[3:0] inside {4'h3, 4'h4, 4'h6}) flow_op = OP_STEP;
      end
      if (m_idx == 4'hF && r[3:0] inside {4'h7, 4'h8, 4'h9}) flow_op = OP_STEP;
      apply();
    end
    @(negedge clk);
    {rst_n, wdt_reset, ce_reset, instr_valid, irq_accept} = 5'b10000;
    for (int k = 0; k < 10 && notes.size() > 0; k++) @(negedge clk);
    if (notes.size() > 0) miscompares++;
    @(negedge clk);
    $display("random flow test done");
    test_done();
  end
endmodule : test_program_counter_sequencer
`default_nettype wire
